//--- rtl/rxc_consts.svh
// offsets, field positions, reset values and pattern constants of the receive clock control block
`ifndef RXC_CONSTS_SVH
`define RXC_CONSTS_SVH

`define RXC_OFF_CTRL        12'h000
`define RXC_OFF_STATUS      12'h004
`define RXC_OFF_BOUNDARY    12'h008

`define RXC_CTRL_SRC_LSB    0
`define RXC_CTRL_DEC_LSB    2
`define RXC_CTRL_FRAME_LSB  4
`define RXC_CTRL_STYLE_LSB  6
`define RXC_CTRL_RECOVERED_CLOCK_RATE_SEL_BIT 8
`define RXC_CTRL_REFRATE_BIT 9
`define RXC_CTRL_WIDTH      10

// three-level fields reset to mid (floating pin), two-level ones to low (pull-down)
`define RXC_CTRL_RESET      10'h055

`define RXC_LVL_LOW         2'h0
`define RXC_LVL_MID         2'h1
`define RXC_LVL_HIGH        2'h2

// span of 50 bits holds at most 4 character starts after the first one
`define RXC_SPAN_GAP_MAX    3'h3
`define RXC_GAP_SAT         3'h7
`define RXC_RUN_NEEDED      2'h3

`define RXC_PAT_K285_NEG    10'h0fa
`define RXC_PAT_K285_POS    10'h305
`define RXC_MASK_FULL       10'h3ff
`define RXC_MASK_COMMA8     10'h3fc

`endif

//--- rtl/rxc_pkg.sv
// types shared by the receive clock control block
`default_nettype none
package rxc_pkg;

    typedef enum logic [1:0] {RXC_LOW, RXC_MID, RXC_HIGH} rxc_lvl_t;

    typedef struct packed {
        logic       tick;
        logic [9:0] raw;
        logic [7:0] dec_data;
        logic [2:0] dec_stat;
        logic       comma_hit;
        logic [3:0] comma_off;
    } rxc_chan_in_t;

    typedef struct packed {
        logic [9:0] pat_neg;
        logic [9:0] pat_pos;
        logic [9:0] mask;
        logic       realign_en;
        logic [1:0] style;
        logic       decoder_bypass;
        logic       decoder_table_alt;
    } rxc_frame_cfg_t;

    typedef struct packed {
        logic [31:0]     prdata;
        logic [9:0]      ctrl;
        logic            ref_s1;
        logic            ref_s2;
        logic            ref_prev;
        logic            ref_a;
        logic            ref_c;
        logic            rf_s1;
        logic            rf_s2;
        logic [3:0]      phase;
        logic [3:0]      clk_true;
        logic [3:0]      clk_oe_n;
        logic [3:0][7:0] data;
        logic [3:0][2:0] stat;
        logic [3:0]      par;
        logic [3:0][3:0] boundary;
        logic [3:0][3:0] last_off;
        logic [3:0][2:0] gap;
        logic [3:0][1:0] run;
        logic [3:0]      stretch;
    } rxc_state_t;

endpackage
`default_nettype wire

//--- rtl/rxc_ctrl.sv
// output clock source, output register loading and framer control of a four-channel receiver
`include "rxc_consts.svh"
`default_nettype none

// Operation
// - rate high: recovered clock pairs run complementary at half character rate.
// - reference source selected: receive rate select ignored, A and C follow reference.
// - reference half rate: A and C outputs half rate, following reference.
// - reference full rate: A and C outputs full rate, following reference.
// - framing select mid: search eight-bit comma, both disparities.
// - framing select high: search full K28.5, both disparities.
// - reframe enable high lets all four framers realign; sampled asynchronously.
// - half-rate reference: outputs change on both reference edges; host captures both.
// - three-level inputs decode low, mid, high; unconnected counts as mid.
// - recovered mode: clock pairs run continuously at character or dual-character rate.
// - source low: all registers load from reference; B and D clocks high impedance.
// - reference mode: A and C carry delayed reference copies of slightly different phase.
// - source mid: each pair follows its own recovered clock and times its data.
// - rate low: pairs run complementary at full character rate.
// - decoder select low bypasses decoder; mid and high pick special-code tables.
// - reframe style low: realign on every framing character, stretching character clock.
// - style mid: realign after two same-boundary characters within fifty bits.
module rxc_ctrl
    import rxc_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 ce,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // pins from outside
    input  wire logic                 training_ref_clock,
    input  wire logic                 reframe_enable_all,
    // per-channel recovered path
    input  wire rxc_chan_in_t [3:0]   chan_in,
    // clock output pins
    output logic      [3:0]           channel_char_clock_out,
    output logic      [3:0]           channel_char_clock_out_n,
    output logic      [3:0]           channel_char_clock_oe_n,
    // parallel output registers
    output logic      [3:0][7:0]      channel_parallel_data,
    output logic      [3:0][2:0]      channel_char_status,
    output logic      [3:0]           channel_odd_parity_out,
    // framer control
    output rxc_frame_cfg_t            frame_cfg,
    output logic      [3:0][3:0]      frame_boundary,
    output logic      [3:0]           frame_stretch
);

    rxc_state_t s;
    rxc_state_t next_s;

    function automatic rxc_lvl_t lvl(input logic [1:0] code);
        if (code == `RXC_LVL_LOW) begin
            return RXC_LOW;
        end else if (code == `RXC_LVL_HIGH) begin
            return RXC_HIGH;
        end else begin
            return RXC_MID;
        end
    endfunction

    function automatic logic [31:0] rd_mux(input rxc_state_t st, input logic [11:0] addr);
        if (addr == `RXC_OFF_CTRL) begin
            return {22'h000000, st.ctrl};
        end else if (addr == `RXC_OFF_STATUS) begin
            return {24'h000000, st.clk_oe_n, 1'b0, st.ref_s2, st.rf_s2,
                    st.ctrl[`RXC_CTRL_FRAME_LSB +: 2] == `RXC_LVL_LOW};
        end else if (addr == `RXC_OFF_BOUNDARY) begin
            return {16'h0000, st.boundary};
        end else begin
            return 32'h00000000;
        end
    endfunction

    rxc_lvl_t src;
    rxc_lvl_t dec;
    rxc_lvl_t frm;
    rxc_lvl_t sty;
    logic     rx_half;
    logic     ref_half;
    logic     ref_rise;
    logic     ref_fall;
    logic     hit_addr;

    assign src      = lvl(s.ctrl[`RXC_CTRL_SRC_LSB +: 2]);
    assign dec      = lvl(s.ctrl[`RXC_CTRL_DEC_LSB +: 2]);
    assign frm      = lvl(s.ctrl[`RXC_CTRL_FRAME_LSB +: 2]);
    assign sty      = lvl(s.ctrl[`RXC_CTRL_STYLE_LSB +: 2]);
    assign rx_half  = s.ctrl[`RXC_CTRL_RECOVERED_CLOCK_RATE_SEL_BIT];
    assign ref_half = s.ctrl[`RXC_CTRL_REFRATE_BIT];
    assign ref_rise = s.ref_s2 & ~s.ref_prev;
    assign ref_fall = ~s.ref_s2 & s.ref_prev;
    assign hit_addr = (paddr == `RXC_OFF_CTRL) || (paddr == `RXC_OFF_STATUS) || (paddr == `RXC_OFF_BOUNDARY);

    // zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_addr;

    always_comb begin
        logic       load;
        logic       same;
        logic [7:0] d;
        logic [2:0] st;
        next_s = s;
        load   = 1'b0;
        same   = 1'b0;
        d      = 8'h00;
        st     = 3'h0;

        // apb: read data captured in setup so it is a flop in the access cycle
        if (psel && !penable) begin
            next_s.prdata = rd_mux(s, paddr);
        end
        if (psel && penable && pwrite && paddr == `RXC_OFF_CTRL) begin
            next_s.ctrl = pwdata[`RXC_CTRL_WIDTH-1:0];
        end

        // pins cross in through two flops; only the second is looked at
        next_s.ref_s1   = training_ref_clock;
        next_s.ref_s2   = s.ref_s1;
        next_s.ref_prev = s.ref_s2;
        next_s.rf_s1    = reframe_enable_all;
        next_s.rf_s2    = s.rf_s1;
        // two delay taps of the reference give the A and C copies their phase offset
        next_s.ref_a    = s.ref_s2;
        next_s.ref_c    = s.ref_a;

        for (int i = 0; i < 4; i++) begin
            // clock pins
            if (src == RXC_LOW) begin
                // rate select not consulted here; the pair simply follows the reference
                next_s.clk_true[i] = (i == 0) ? s.ref_a : (i == 2) ? s.ref_c : 1'b0;
                next_s.clk_oe_n[i] = (i == 1 || i == 3);
            end else begin
                next_s.clk_oe_n[i] = (src == RXC_HIGH) && (i == 1 || i == 3);
                if (chan_in[i].tick) begin
                    next_s.phase[i] = ~s.phase[i];
                end
                if (rx_half) begin
                    next_s.clk_true[i] = chan_in[i].tick ? ~s.phase[i] : s.phase[i];
                end else begin
                    next_s.clk_true[i] = chan_in[i].tick;
                end
            end

            // output registers
            if (src == RXC_LOW) begin
                load = ref_rise || (ref_half && ref_fall);
            end else begin
                load = chan_in[i].tick;
            end
            if (dec == RXC_LOW) begin
                d  = chan_in[i].raw[9:2];
                st = {chan_in[i].comma_hit, chan_in[i].raw[1:0]};
            end else begin
                d  = chan_in[i].dec_data;
                st = chan_in[i].dec_stat;
            end
            if (load) begin
                next_s.data[i] = d;
                next_s.stat[i] = st;
                next_s.par[i]  = ~(^d);
            end

            // framer boundary tracking, once per character
            next_s.stretch[i] = 1'b0;
            if (chan_in[i].tick) begin
                same = chan_in[i].comma_hit && (chan_in[i].comma_off == s.last_off[i]);
                if (chan_in[i].comma_hit) begin
                    next_s.last_off[i] = chan_in[i].comma_off;
                    next_s.gap[i]      = 3'h0;
                    next_s.run[i]      = (same && s.run[i] != `RXC_RUN_NEEDED) ? s.run[i] + 2'h1 : s.run[i];
                    if (!same) begin
                        next_s.run[i] = 2'h0;
                    end
                end else begin
                    next_s.run[i] = 2'h0;
                    if (s.gap[i] != `RXC_GAP_SAT) begin
                        next_s.gap[i] = s.gap[i] + 3'h1;
                    end
                end
                // with enable low nothing below moves the boundary
                if (s.rf_s2 && chan_in[i].comma_hit) begin
                    if (sty == RXC_LOW) begin
                        next_s.boundary[i] = chan_in[i].comma_off;
                        next_s.stretch[i]  = chan_in[i].comma_off != s.boundary[i];
                    end else if (sty == RXC_MID) begin
                        if (same && s.gap[i] <= `RXC_SPAN_GAP_MAX) begin
                            next_s.boundary[i] = chan_in[i].comma_off;
                        end
                    end else begin
                        if (same && s.run[i] == `RXC_RUN_NEEDED - 2'h1) begin
                            next_s.boundary[i] = chan_in[i].comma_off;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s          <= '0;
            s.ctrl     <= `RXC_CTRL_RESET;
            s.clk_oe_n <= 4'h0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign prdata                   = s.prdata;
    assign channel_char_clock_out   = s.clk_true;
    assign channel_char_clock_out_n = ~s.clk_true;
    assign channel_char_clock_oe_n  = s.clk_oe_n;
    assign channel_parallel_data    = s.data;
    assign channel_char_status      = s.stat;
    assign channel_odd_parity_out   = s.par;
    assign frame_boundary           = s.boundary;
    assign frame_stretch            = s.stretch;

    // the framer itself compares; this block names the pattern and mask and passes enable, style and decoder selects
    always_comb begin
        frame_cfg.pat_neg           = `RXC_PAT_K285_NEG;
        frame_cfg.pat_pos           = `RXC_PAT_K285_POS;
        frame_cfg.mask              = (frm == RXC_HIGH) ? `RXC_MASK_FULL : `RXC_MASK_COMMA8;
        frame_cfg.realign_en        = s.rf_s2;
        frame_cfg.style             = s.ctrl[`RXC_CTRL_STYLE_LSB +: 2];
        frame_cfg.decoder_bypass    = dec == RXC_LOW;
        frame_cfg.decoder_table_alt = dec == RXC_HIGH;
    end

endmodule
`default_nettype wire

//--- verif/rxc_ctrl_monitor.sv
// concurrent checks on the ports of the receive clock control block
`default_nettype none
module rxc_ctrl_monitor
    import rxc_pkg::*;
(
    // clock, reset, apb
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                ce,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pslverr,
    // pins and channel path
    input wire logic                training_ref_clock,
    input wire logic                reframe_enable_all,
    input wire rxc_chan_in_t [3:0]  chan_in,
    // outputs watched
    input wire logic [3:0]          channel_char_clock_out,
    input wire logic [3:0]          channel_char_clock_out_n,
    input wire logic [3:0]          channel_char_clock_oe_n,
    input wire logic [3:0][7:0]     channel_parallel_data,
    input wire logic [3:0]          channel_odd_parity_out,
    input wire rxc_frame_cfg_t      frame_cfg,
    input wire logic [3:0][3:0]     frame_boundary
);
    logic [9:0] sh;
    logic [2:0] cnt;
    wire        wr0 = psel && penable && pwrite && ce && paddr == 12'h000;
    // mode checks wait until a new setting has had time to reach the flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh  <= 10'h055;
            cnt <= 3'h0;
        end else if (wr0) begin
            sh  <= pwdata[9:0];
            cnt <= 3'h0;
        end else if (cnt != 3'h7) begin
            cnt <= cnt + 3'h1;
        end
    end
    wire st   = cnt > 3'h4;
    wire slo  = st && sh[1:0] == 2'h0;
    wire smid = st && (sh[1:0] == 2'h1 || sh[1:0] == 2'h3);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    bd_tristate_a: assert property (slo |-> channel_char_clock_oe_n[1] && channel_char_clock_oe_n[3])
        else $error("b or d clock driven in reference mode");
    mid_driven_a: assert property (smid |-> channel_char_clock_oe_n == 4'h0)
        else $error("clock pin released in recovered mode");
    ref_follow_a: assert property (slo |-> channel_char_clock_out[0] == $past(training_ref_clock, 4)
        && channel_char_clock_out[2] == $past(training_ref_clock, 5)) else $error("a or c not tracking reference");
    pair_comp_a: assert property (channel_char_clock_out_n == ~channel_char_clock_out)
        else $error("clock pair not complementary");
    rate_low_a: assert property (smid && !sh[8] && chan_in[0].tick |=> channel_char_clock_out[0])
        else $error("full rate clock not high after character");
    rate_high_a: assert property (smid && sh[8] && chan_in[0].tick |=> $changed(channel_char_clock_out[0]))
        else $error("half rate clock did not toggle");
    raw_load_a: assert property (smid && sh[3:2] == 2'h0 && chan_in[0].tick |=>
        channel_parallel_data[0] == $past(chan_in[0].raw[9:2]) && channel_odd_parity_out[0] == ~^channel_parallel_data[0])
        else $error("raw character not loaded");
    frame_pat_a: assert property (frame_cfg.mask == (sh[5:4] == 2'h2 ? 10'h3ff : 10'h3fc)
        && frame_cfg.pat_neg == 10'h0fa && frame_cfg.pat_pos == 10'h305) else $error("framing pattern wrong");
    sync_en_a: assert property (st |-> frame_cfg.realign_en == $past(reframe_enable_all, 2))
        else $error("reframe enable not synchronised");
    hold_bound_a: assert property (!frame_cfg.realign_en |=> $stable(frame_boundary))
        else $error("boundary moved while reframing off");
    low_latency_a: assert property (st && sh[7:6] == 2'h0 && frame_cfg.realign_en && chan_in[0].tick
        && chan_in[0].comma_hit |=> frame_boundary[0] == $past(chan_in[0].comma_off)) else $error("no realign");
    cover property (slo && training_ref_clock);
    cover property (smid && sh[8] && chan_in[0].tick);
    cover property (psel && penable && pslverr);
endmodule
bind rxc_ctrl rxc_ctrl_monitor u_mon (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .training_ref_clock, .reframe_enable_all, .chan_in, .channel_char_clock_out, .channel_char_clock_out_n,
    .channel_char_clock_oe_n, .channel_parallel_data, .channel_odd_parity_out, .frame_cfg, .frame_boundary);
`default_nettype wire

//--- verif/rxc_host_model.sv
// host capture model: counts the words it would latch on channel a clocks
`default_nettype none
module rxc_host_model (
    // clock pair and capture mode
    input wire logic  clk_true,
    input wire logic  clk_comp,
    input wire logic  both_edges,
    // words captured so far
    output var int    n_caps
);
    int n_true = 0;
    int n_comp = 0;
    always @(posedge clk_true) n_true++;
    // complement edge only counts where alternate or dual edge capture applies
    always @(posedge clk_comp) if (both_edges) n_comp++;
    assign n_caps = n_true + n_comp;
endmodule
`default_nettype wire

//--- verif/rxc_ctrl_tb_top.sv
// self-checking testbench of the receive clock control block
`default_nettype none
module rxc_ctrl_tb_top
    import rxc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [9:0] ctrl; logic [3:0] oe; logic [9:0] mask; logic flag;} rxc_row_t;
    logic pclk = 1'b0, presetn, ce, psel, penable, pwrite, pready, pslverr, err, both;
    logic training_ref_clock, reframe_enable_all;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    rxc_chan_in_t [3:0] chan_in;
    logic [3:0] channel_char_clock_out, channel_char_clock_out_n, channel_char_clock_oe_n, channel_odd_parity_out;
    logic [3:0][7:0] channel_parallel_data;
    rxc_frame_cfg_t frame_cfg;
    int failures = 0, n_compared = 0, cyc = 0, caps, c0;
    rxc_row_t rows [5] = '{'{10'h055, 4'h0, 10'h3fc, 1'b0}, '{10'h065, 4'h0, 10'h3ff, 1'b0},
        '{10'h354, 4'ha, 10'h3fc, 1'b0}, '{10'h056, 4'ha, 10'h3fc, 1'b0}, '{10'h045, 4'h0, 10'h3fc, 1'b1}};
    rxc_ctrl dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .training_ref_clock, .reframe_enable_all, .chan_in, .channel_char_clock_out, .channel_char_clock_out_n,
        .channel_char_clock_oe_n, .channel_parallel_data, .channel_char_status(), .channel_odd_parity_out,
        .frame_cfg, .frame_boundary(), .frame_stretch());
    rxc_host_model host (.clk_true(channel_char_clock_out[0]), .clk_comp(channel_char_clock_out_n[0]),
        .both_edges(both), .n_caps(caps));
    always #2 pclk = ~pclk;
    task automatic stop_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            stop_test;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never reassigns psel in this time step
        @(posedge pclk);
    endtask
    task automatic tick(input logic [9:0] raw, input logic hit, input logic [3:0] off);
        chan_in[0] <= {1'b1, raw, 8'h00, 3'h0, hit, off};
        @(posedge pclk);
        chan_in[0] <= '0;
        repeat (2) @(posedge pclk);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, both, training_ref_clock, reframe_enable_all} = '0;
        ce = 1'b1;
        chan_in = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h055, rd);
        $display("reset test done");
        foreach (rows[i]) begin
            apb(1'b1, 12'h000, 32'(rows[i].ctrl));
            repeat (2) @(posedge pclk);
            apb(1'b0, 12'h004, 32'h0);
            chk("clock oe_n", 32'(rows[i].oe), 32'(channel_char_clock_oe_n));
            chk("frame mask", 32'(rows[i].mask), 32'(frame_cfg.mask));
            chk("reserved flag", 32'(rows[i].flag), 32'(rd[0]));
        end
        $display("row test done");
        apb(1'b1, 12'h00c, 32'h1);
        chk("unmapped error", 32'h1, 32'(err));
        // recovered clock: rate low then half rate, four characters each
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 12'h000, m ? 32'h151 : 32'h051);
            both <= m[0];
            repeat (6) @(posedge pclk);
            c0 = caps;
            repeat (4) tick(10'h2b7, 1'b0, 4'h0);
            chk("recovered edges", 32'd4, 32'(caps - c0));
        end
        chk("raw data", 32'h0ad, 32'(channel_parallel_data[0]));
        chk("odd parity", 32'h0, 32'(channel_odd_parity_out[0]));
        $display("recovered test done");
        // reference clock: half rate then full rate, receive rate left high
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 12'h000, m ? 32'h154 : 32'h354);
            both <= !m[0];
            repeat (6) @(posedge pclk);
            c0 = caps;
            repeat (6) begin
                training_ref_clock <= !training_ref_clock;
                repeat (4) @(posedge pclk);
            end
            repeat (6) @(posedge pclk);
            chk("reference edges", m ? 32'd3 : 32'd6, 32'(caps - c0));
        end
        $display("reference test done");
        apb(1'b1, 12'h000, 32'h015);
        tick(10'h0fa, 1'b1, 4'h5);
        apb(1'b0, 12'h008, 32'h0);
        chk("boundary held", 32'h0, rd);
        reframe_enable_all <= 1'b1;
        repeat (4) @(posedge pclk);
        tick(10'h0fa, 1'b1, 4'h5);
        apb(1'b0, 12'h008, 32'h0);
        chk("boundary low latency", 32'h5, rd);
        apb(1'b1, 12'h000, 32'h055);
        tick(10'h0fa, 1'b1, 4'h9);
        repeat (2) tick(10'h2b7, 1'b0, 4'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("boundary one hit", 32'h5, rd);
        tick(10'h0fa, 1'b1, 4'h9);
        apb(1'b0, 12'h008, 32'h0);
        chk("boundary pair", 32'h9, rd);
        // style high needs four adjacent hits on one offset
        apb(1'b1, 12'h000, 32'h095);
        repeat (3) tick(10'h0fa, 1'b1, 4'h3);
        apb(1'b0, 12'h008, 32'h0);
        chk("boundary three hits", 32'h9, rd);
        tick(10'h0fa, 1'b1, 4'h3);
        apb(1'b0, 12'h008, 32'h0);
        chk("boundary four hits", 32'h3, rd);
        $display("reframe test done");
        stop_test;
    end
endmodule
`default_nettype wire
